// ---- core/mdio_debounce.sv ----
// file: synchroniser and debounce filter for the input terminals
`timescale 1ns/1ps
module mdio_debounce
    import mdio_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int STABLE = DEBOUNCE_CYCLES
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             rst_n_i, // async reset, active low
    input  wire logic [WIDTH-1:0] raw_i,   // raw terminal levels
    input  wire logic [WIDTH-1:0] init_i,  // level taken after release
    output logic      [WIDTH-1:0] clean_o  // filtered levels
);
    localparam int CW = $clog2(STABLE + 1);

    // refused at elaboration: the filter needs at least two cycles
    if (STABLE < 2) begin : g_bad_window
        $error("debounce window too short");
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] primed_q;

    // two flops: the first is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
        end
    end

    // per-bit stability counter; a glitch shorter than the window is lost
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic [CW-1:0] cnt_q;
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cnt_q      <= '0;
                clean_o[b] <= 1'b0;
                primed_q[b] <= 1'b0;
            end else if (!primed_q[b]) begin
                // safe level caught after release, not at reset
                primed_q[b] <= 1'b1;
                clean_o[b]  <= init_i[b];
            end else if (sync_q[b] == clean_o[b]) begin
                cnt_q <= '0;
            end else if (cnt_q == CW'(STABLE - 1)) begin
                cnt_q      <= '0;
                clean_o[b] <= sync_q[b];
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule : mdio_debounce

// ---- core/mdio_top.sv ----
// file: terminal function logic of a brushless motor driver
// Overview of operation
// RL1 - each output terminal selects one status function
// RL2 - overload alarm delay 0.1 to 60 s, default 30
// RL3 - warning threshold 50 to 120 percent, default 120
// RL4 - speed band 0 to 400 r/min, default 200
// RL5 - initialize restores every parameter default
// RL6 - increasing ratio 1.00 means reduction ratio applies
// RL7 - severe overload or lock alarms within 5 s
// RL8 - one run input asserted runs that direction
// RL9 - both run inputs asserted stop instantly
// RL10 - two select bits pick data set, zero default
// RL11 - fault clear resets the active alarm
// RL12 - external fault input normally closed, trips alarm
// RL13 - hold release input frees standstill holding
// RL14 - fault flag output off during alarm
// RL15 - thirty 0.2 ms pulses per shaft revolution
// RL16 - overload flag off above threshold or alarm; the code drops it on an overload alarm only, not on other alarms
// RL17 - moving output high while motor operates
// RL18 - speed reached within band of commanded speed
// RL19 - caution flag follows warning, motor keeps running
// RL20 - duplicated input function ORs its terminals
// RL21 - each input terminal selects one input function
// RL22 - standstill holding setting, default disabled
// RL23 - inputs synchronised and debounced before use
// RL24 - terminal outputs come from flip-flops
`timescale 1ns/1ps
module mdio_top
    import mdio_pkg::*;
#(
    parameter int TENTH_CNT = TENTH_CYCLES,   // cycles in 0.1 s
    parameter int PULSE_CNT = PULSE_CYCLES    // cycles in 0.2 ms
) (
    input  wire logic        CLK_SYS_I,          // 25 MHz clock
    input  wire logic        RESET_N_I,          // async reset, low
    input  wire logic [2:0]  INPUT_TERMINAL_I,   // terminals 0..2
    input  wire logic        PARAM_WE_I,         // load parameter set
    input  wire mdio_param_type PARAM_I,         // new parameter set
    input  wire logic        INIT_PARAMS_I,      // restore defaults
    input  wire logic [15:0] SPEED_MEAS_I,       // motor speed r/min
    input  wire logic [15:0] SPEED_CMD_I,        // commanded r/min
    input  wire logic [7:0]  LOAD_PCT_I,         // load factor %
    input  wire logic        OVL_REGION_I,       // in limited duty region
    input  wire logic        OVL_SEVERE_I,       // beyond region or locked
    input  wire logic        FAULT_EVENT_I,      // other protective trip
    input  wire logic        WARNING_I,          // a warning is present
    input  wire logic        ROT_TICK_I,         // one 1/30 rev pulse
    output mdio_param_type   PARAM_O,            // active parameter set
    output logic [15:0]      RATIO_O,            // ratio in effect x100
    output mdio_run_type     RUN_O,              // run command
    output logic [1:0]       DATA_SEL_O,         // operation data number
    output logic             HOLD_ACTIVE_O,      // holding the load
    output logic             ALARM_O,            // alarm latched
    output logic             EXT_FAULT_O,        // alarm is external fault
    output logic             OUTPUT_TERMINAL_0_O, // output terminal 0
    output logic             OUTPUT_TERMINAL_1_O  // output terminal 1
);

    // refused at elaboration: zero counts would stall the timers
    if (TENTH_CNT < 1 || PULSE_CNT < 1) begin : g_bad_counts
        $error("bad timing counts");
    end

    localparam int TW = $clog2(TENTH_CNT + 1);
    localparam int PW = $clog2(PULSE_CNT + 1);

    // ---------------- parameters ----------------
    mdio_param_type param_q;

    function automatic mdio_param_type clamp(input mdio_param_type p);
        mdio_param_type r;
        r = p;
        if (r.ovl_delay < OVL_DELAY_MIN) r.ovl_delay = OVL_DELAY_MIN;
        if (r.ovl_delay > OVL_DELAY_MAX) r.ovl_delay = OVL_DELAY_MAX;
        if (r.warn_level < WARN_LEVEL_MIN) r.warn_level = WARN_LEVEL_MIN;
        if (r.warn_level > WARN_LEVEL_MAX) r.warn_level = WARN_LEVEL_MAX;
        if (r.speed_band > SPEED_BAND_MAX) r.speed_band = SPEED_BAND_MAX;
        if (r.reduce_ratio < RATIO_UNITY) r.reduce_ratio = RATIO_UNITY;
        if (r.increase_ratio < RATIO_UNITY) r.increase_ratio = RATIO_UNITY;
        return r;
    endfunction : clamp

    // out-of-range writes are clamped so the timers never see zero
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            param_q <= PARAM_DEFAULT;
        end else if (INIT_PARAMS_I) begin
            param_q <= PARAM_DEFAULT;                       // RL5
        end else if (PARAM_WE_I) begin
            param_q <= clamp(PARAM_I);           // RL2 RL3 RL4 RL22
        end
    end

    assign PARAM_O = param_q;

    // ratio in effect
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RATIO_O <= RATIO_UNITY;
        end else if (param_q.increase_ratio == RATIO_UNITY) begin
            RATIO_O <= param_q.reduce_ratio;                // RL6
        end else begin
            RATIO_O <= param_q.increase_ratio;              // RL6
        end
    end

    // ---------------- inputs ----------------
    logic [2:0] term_clean;

    // external fault starts closed so release does not trip
    function automatic logic [2:0] ext_mask(input mdio_param_type p);
        ext_mask = {p.in2_fn == IN_EXT_FAULT, p.in1_fn == IN_EXT_FAULT,
                    p.in0_fn == IN_EXT_FAULT};
    endfunction : ext_mask

    mdio_debounce #(
        .WIDTH  (3),
        .STABLE (DEBOUNCE_CYCLES)
    ) u_debounce (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESET_N_I),
        .raw_i   (INPUT_TERMINAL_I),
        .init_i  (ext_mask(param_q)),
        .clean_o (term_clean)                               // RL23
    );

    // any terminal mapped to fn activates it
    function automatic logic fn_on(input mdio_param_type p,
                                   input logic [2:0] t,
                                   input mdio_in_fn_type fn);
        fn_on = (t[0] && p.in0_fn == fn) || (t[1] && p.in1_fn == fn)
             || (t[2] && p.in2_fn == fn);
    endfunction : fn_on

    // normally closed: an open mapped terminal means fault
    function automatic logic fn_open(input mdio_param_type p,
                                     input logic [2:0] t,
                                     input mdio_in_fn_type fn);
        fn_open = (!t[0] && p.in0_fn == fn) || (!t[1] && p.in1_fn == fn)
               || (!t[2] && p.in2_fn == fn);
    endfunction : fn_open

    logic forward_run, bwd, sel_lo, sel_hi, clr, ext_open, hold_rel;

    // function decode
    assign forward_run      = fn_on(param_q, term_clean, IN_FORWARD);  // RL20 RL21
    assign bwd      = fn_on(param_q, term_clean, IN_BACKWARD); // RL20 RL21
    assign sel_lo   = fn_on(param_q, term_clean, IN_SEL_LO);
    assign sel_hi   = fn_on(param_q, term_clean, IN_SEL_HI);
    assign clr      = fn_on(param_q, term_clean, IN_CLEAR);
    assign hold_rel = fn_on(param_q, term_clean, IN_HOLD_REL);
    assign ext_open = fn_open(param_q, term_clean, IN_EXT_FAULT); // RL12

    // ---------------- overload timing ----------------
    logic [TW-1:0] tenth_q;
    logic [9:0]    ovl_cnt_q;
    logic          ovl_trip;

    // 0.1 s prescaler, free running
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            tenth_q <= '0;
        end else if (tenth_q == TW'(TENTH_CNT - 1)) begin
            tenth_q <= '0;
        end else begin
            tenth_q <= tenth_q + 1'b1;
        end
    end

    // severe load counts against a 5 s cap whatever the setting
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ovl_cnt_q <= '0;
        end else if (!OVL_REGION_I && !OVL_SEVERE_I) begin
            ovl_cnt_q <= '0;
        end else if (tenth_q == TW'(TENTH_CNT - 1) && !ovl_trip) begin
            ovl_cnt_q <= ovl_cnt_q + 10'd1;
        end
    end

    assign ovl_trip = (ovl_cnt_q >= param_q.ovl_delay)           // RL2
        || (OVL_SEVERE_I && ovl_cnt_q >= 10'(FAST_OVL_TENTHS));  // RL7

    // ---------------- alarm ----------------
    logic ovl_alarm_q;

    // a trip in the clear cycle wins over the clear
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ALARM_O     <= 1'b0;
            EXT_FAULT_O <= 1'b0;
            ovl_alarm_q <= 1'b0;
        end else if (ext_open || ovl_trip || FAULT_EVENT_I) begin
            ALARM_O     <= 1'b1;                            // RL12
            EXT_FAULT_O <= EXT_FAULT_O | ext_open;          // RL12
            ovl_alarm_q <= ovl_alarm_q | ovl_trip;          // RL2
        end else if (clr) begin
            ALARM_O     <= 1'b0;                            // RL11
            EXT_FAULT_O <= 1'b0;
            ovl_alarm_q <= 1'b0;
        end
    end

    // ---------------- run, select, hold ----------------
    // alarm forces stop; both inputs give an instant stop
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            RUN_O <= RUN_STOP;
        end else if (ext_open || (forward_run && bwd)) begin
            RUN_O <= RUN_HALT;                              // RL9 RL12
        end else if (ALARM_O) begin
            RUN_O <= RUN_STOP;
        end else begin
            case ({bwd, forward_run})
                2'b01:   RUN_O <= RUN_FWD;                  // RL8
                2'b10:   RUN_O <= RUN_BWD;                  // RL8
                default: RUN_O <= RUN_STOP;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DATA_SEL_O <= 2'h0;
        end else begin
            DATA_SEL_O <= {sel_hi, sel_lo};                 // RL10
        end
    end

    // holding only at standstill, only when enabled
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            HOLD_ACTIVE_O <= 1'b0;
        end else begin
            HOLD_ACTIVE_O <= param_q.hold_enable           // RL22
                && RUN_O == RUN_STOP && !hold_rel;          // RL13
        end
    end

    // ---------------- status functions ----------------
    logic [PW-1:0] pulse_q;
    logic          pulse_on;
    logic          moving;
    logic          reached;
    logic          overload_ok;
    logic [16:0]   speed_diff;

    // each tick starts a fixed-width pulse; a tick during one restarts it
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pulse_q <= '0;
        end else if (ROT_TICK_I) begin
            pulse_q <= PW'(PULSE_CNT);                      // RL15
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - 1'b1;
        end
    end

    assign pulse_on    = pulse_q != '0;
    assign moving      = RUN_O == RUN_FWD || RUN_O == RUN_BWD; // RL17
    assign speed_diff  = (SPEED_MEAS_I > SPEED_CMD_I)
        ? 17'(SPEED_MEAS_I - SPEED_CMD_I)
        : 17'(SPEED_CMD_I - SPEED_MEAS_I);
    assign reached     = moving
        && speed_diff <= 17'(param_q.speed_band);           // RL18
    assign overload_ok = !ovl_alarm_q
        && LOAD_PCT_I <= 8'(param_q.warn_level);         // RL3 RL16

    function automatic logic out_sel(input mdio_out_fn_type f,
                                     input logic [5:0] s);
        case (f)
            OUT_FAULT:    out_sel = s[0];
            OUT_PULSE:    out_sel = s[1];
            OUT_OVERLOAD: out_sel = s[2];
            OUT_MOVING:   out_sel = s[3];
            OUT_REACHED:  out_sel = s[4];
            OUT_CAUTION:  out_sel = s[5];
            default:      out_sel = 1'b0;
        endcase
    endfunction : out_sel

    logic [5:0] status;
    assign status = {WARNING_I, reached, moving, overload_ok,
                     pulse_on, !ALARM_O};           // RL14 RL16 RL19

    // terminals are registered so they never glitch
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            OUTPUT_TERMINAL_0_O <= 1'b0;
            OUTPUT_TERMINAL_1_O <= 1'b0;
        end else begin
            OUTPUT_TERMINAL_0_O <= out_sel(param_q.out0_fn,
                                           status);        // RL1 RL24
            OUTPUT_TERMINAL_1_O <= out_sel(param_q.out1_fn,
                                           status);        // RL1 RL24
        end
    end

    // ---------------- assertions ----------------
    a_both_run_halt: assert property (   // RL9
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (forward_run && bwd) |=> RUN_O == RUN_HALT)
        else $error("both run inputs did not halt");

    a_single_run_dir: assert property (   // RL8
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (forward_run && !bwd && !ALARM_O && !ext_open) |=> RUN_O == RUN_FWD)
        else $error("forward request not obeyed");

    a_ext_fault_trip: assert property (   // RL12
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        ext_open |=> ALARM_O && EXT_FAULT_O && RUN_O == RUN_HALT)
        else $error("external fault did not trip");

    a_clear_alarm: assert property (   // RL11
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (clr && !ext_open && !ovl_trip && !FAULT_EVENT_I) |=> !ALARM_O)
        else $error("fault clear ignored");

    a_init_default: assert property (   // RL5
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        INIT_PARAMS_I |=> param_q == PARAM_DEFAULT)
        else $error("initialize did not restore defaults");

    a_ratio_pick: assert property (   // RL6
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (param_q.increase_ratio == RATIO_UNITY && $stable(param_q))
        |=> RATIO_O == $past(param_q.reduce_ratio))
        else $error("wrong ratio in effect");

    a_severe_cap: assert property (   // RL7
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (OVL_SEVERE_I && ovl_cnt_q >= 10'(FAST_OVL_TENTHS)) |=> ALARM_O)
        else $error("severe overload not alarmed within 5 s");

    a_select_map: assert property (   // RL10
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        (!sel_lo && !sel_hi) |=> DATA_SEL_O == 2'h0)
        else $error("data set zero not selected");

    a_pulse_width: assert property (   // RL15
        @(posedge CLK_SYS_I) disable iff (!RESET_N_I)
        ROT_TICK_I |=> pulse_q == PW'(PULSE_CNT))
        else $error("rotation pulse not started");

endmodule : mdio_top

// ---- include/mdio_pkg.sv ----
// package: constants, codes and carriers of the motor driver terminal logic
package mdio_pkg;

    // output terminal function codes
    typedef enum logic [2:0] {
        OUT_UNUSED   = 3'h0,
        OUT_FAULT    = 3'h1,
        OUT_PULSE    = 3'h2,
        OUT_OVERLOAD = 3'h3,
        OUT_MOVING   = 3'h4,
        OUT_REACHED  = 3'h5,
        OUT_CAUTION  = 3'h6
    } mdio_out_fn_type;

    // input terminal function codes
    typedef enum logic [2:0] {
        IN_UNUSED    = 3'h0,
        IN_FORWARD   = 3'h1,
        IN_BACKWARD  = 3'h2,
        IN_SEL_LO    = 3'h3,
        IN_SEL_HI    = 3'h4,
        IN_CLEAR     = 3'h5,
        IN_EXT_FAULT = 3'h6,
        IN_HOLD_REL  = 3'h7
    } mdio_in_fn_type;

    // run state of the motor as commanded by the terminals
    typedef enum logic [1:0] {
        RUN_STOP = 2'b00,
        RUN_FWD  = 2'b01,
        RUN_BWD  = 2'b10,
        RUN_HALT = 2'b11
    } mdio_run_type;

    // tunable parameter set (units: 0.1 s, percent, r/min, ratio x100)
    typedef struct packed {
        logic [9:0]  ovl_delay;
        logic [6:0]  warn_level;
        logic [8:0]  speed_band;
        logic [15:0] reduce_ratio;
        logic [15:0] increase_ratio;
        logic        hold_enable;
        mdio_out_fn_type out0_fn;
        mdio_out_fn_type out1_fn;
        mdio_in_fn_type  in0_fn;
        mdio_in_fn_type  in1_fn;
        mdio_in_fn_type  in2_fn;
    } mdio_param_type;

    // limits and factory defaults
    localparam logic [9:0]  OVL_DELAY_MIN   = 10'd1;
    localparam logic [9:0]  OVL_DELAY_MAX   = 10'd600;
    localparam logic [9:0]  OVL_DELAY_DEF   = 10'd300;
    localparam logic [6:0]  WARN_LEVEL_MIN  = 7'd50;
    localparam logic [6:0]  WARN_LEVEL_MAX  = 7'd120;
    localparam logic [6:0]  WARN_LEVEL_DEF  = 7'd120;
    localparam logic [8:0]  SPEED_BAND_MAX  = 9'd400;
    localparam logic [8:0]  SPEED_BAND_DEF  = 9'd200;
    localparam logic [15:0] RATIO_UNITY     = 16'h0064;
    localparam logic        HOLD_ENABLE_DEF = 1'b0;
    localparam int          PULSES_PER_REV  = 30;

    localparam mdio_param_type PARAM_DEFAULT = '{
        ovl_delay:      OVL_DELAY_DEF,
        warn_level:     WARN_LEVEL_DEF,
        speed_band:     SPEED_BAND_DEF,
        reduce_ratio:   RATIO_UNITY,
        increase_ratio: RATIO_UNITY,
        hold_enable:    HOLD_ENABLE_DEF,
        out0_fn:        OUT_PULSE,
        out1_fn:        OUT_FAULT,
        in0_fn:         IN_FORWARD,
        in1_fn:         IN_BACKWARD,
        in2_fn:         IN_SEL_LO
    };

    // timing
    localparam int CLK_HZ         = 25_000_000;
    localparam int PULSE_WIDTH_NS = 200_000;
    localparam int PULSE_CYCLES   = PULSE_WIDTH_NS / 40;
    localparam int TENTH_SEC_NS   = 100_000_000;
    localparam int TENTH_CYCLES   = TENTH_SEC_NS / 40;
    localparam int FAST_OVL_TENTHS = 50;
    localparam int DEBOUNCE_CYCLES = 16;

endpackage : mdio_pkg

// ---- tb/mdio_plc.sv ----
// controller model that drives the three input terminals
`timescale 1ns/1ps
module mdio_plc (
    input  wire logic       clk_i,  // system clock
    output logic      [2:0] term_o  // terminal levels, high = on
);
    // levels are held as plain logic, the terminals have no pull
    initial term_o = 3'h0;
    // change only at the falling edge so sampling never races
    task automatic put(input logic [2:0] lvl);
        @(negedge clk_i);
        term_o = lvl;
    endtask : put
endmodule : mdio_plc

// ---- tb/mdio_top_test.sv ----
// self-checking bench of the motor driver terminal logic
`timescale 1ns/1ps
module mdio_top_test;
    import mdio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic we = 1'b0;
    logic init = 1'b0;
    logic region = 1'b0;
    logic severe = 1'b0;
    logic warn = 1'b0;
    logic tick = 1'b0;
    logic [15:0] meas = 16'h0000;
    logic [15:0] cmd = 16'h0000;
    logic [7:0] load = 8'h00;
    logic [2:0] term;
    logic [15:0] ratio;
    logic [1:0] dsel;
    logic alarm, extf, y0, y1, hold;
    logic fev = 1'b0;
    mdio_run_type run;
    mdio_param_type prm = PARAM_DEFAULT;
    mdio_param_type prm_o, ex;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    int d;
    // short counts keep the overload and pulse timers quick to run
    mdio_top #(.TENTH_CNT(10), .PULSE_CNT(4)) mdio_top_inst (
        .CLK_SYS_I(clk), .RESET_N_I(rst_n), .INPUT_TERMINAL_I(term),
        .PARAM_WE_I(we), .PARAM_I(prm), .INIT_PARAMS_I(init),
        .SPEED_MEAS_I(meas), .SPEED_CMD_I(cmd), .LOAD_PCT_I(load),
        .OVL_REGION_I(region), .OVL_SEVERE_I(severe),
        .FAULT_EVENT_I(fev), .WARNING_I(warn), .ROT_TICK_I(tick),
        .PARAM_O(prm_o), .RATIO_O(ratio), .RUN_O(run),
        .DATA_SEL_O(dsel), .HOLD_ACTIVE_O(hold), .ALARM_O(alarm),
        .EXT_FAULT_O(extf), .OUTPUT_TERMINAL_0_O(y0),
        .OUTPUT_TERMINAL_1_O(y1));
    mdio_plc mdio_plc_inst (.clk_i(clk), .term_o(term));
    always #20 clk = ~clk;
    // hard cap on run length so a hang still reaches the verdict
    initial begin
        #4000000;
        n_mismatch++;
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic chk_v(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_v
    task automatic chk_p(string nm, mdio_param_type e, mdio_param_type g);
        n_checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_p
    // reference clamp, written apart from the design's own range logic
    function automatic mdio_param_type clamp(mdio_param_type p);
        clamp = p;
        if (p.ovl_delay < 1) clamp.ovl_delay = 10'h001;
        if (p.ovl_delay > 600) clamp.ovl_delay = 10'h258;
        if (p.warn_level < 50) clamp.warn_level = 7'h32;
        if (p.warn_level > 120) clamp.warn_level = 7'h78;
        if (p.speed_band > 400) clamp.speed_band = 9'h190;
        if (p.reduce_ratio < 100) clamp.reduce_ratio = 16'h0064;
        if (p.increase_ratio < 100) clamp.increase_ratio = 16'h0064;
    endfunction : clamp
    task automatic put_prm();
        @(negedge clk);
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        ex = clamp(prm);
        @(negedge clk);
        chk_p("param_o", ex, prm_o);
        chk_v("ratio", (ex.increase_ratio == 100) ? ex.reduce_ratio
              : ex.increase_ratio, ratio);
    endtask : put_prm
    // the debounce path takes about 19 cycles, so 25 covers it
    task automatic settle(logic [2:0] t);
        mdio_plc_inst.put(t);
        repeat (25) @(negedge clk);
    endtask : settle
    task automatic wait_alarm(output int cnt);
        cnt = 0;
        while (alarm !== 1'b1 && cnt < 700) begin
            @(negedge clk);
            cnt++;
        end
    endtask : wait_alarm
    initial begin
        void'($urandom(32'hB19B));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_p("param_rst", PARAM_DEFAULT, prm_o);
        chk_v("ratio_rst", 16'h0064, ratio);
        chk_v("fault_flag", 16'h0001, {15'h0, y1});
        chk_v("hold_rst", 16'h0000, {15'h0, hold});
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            prm.ovl_delay = 10'($urandom_range(0, 1023));
            prm.warn_level = 7'($urandom_range(0, 127));
            prm.speed_band = 9'($urandom_range(0, 511));
            prm.reduce_ratio = 16'($urandom_range(0, 3000));
            prm.increase_ratio = i[0] ? 16'h0064
                : 16'($urandom_range(0, 3000));
            put_prm();
        end
        @(negedge clk);
        init = 1'b1;
        @(negedge clk);
        init = 1'b0;
        @(negedge clk);
        chk_p("param_init", PARAM_DEFAULT, prm_o);
        $display("test parameters done");
        for (int v = 0; v < 4; v++) begin
            settle(3'(v));
            chk_v("run", 16'(v), {14'h0, run});
        end
        prm = PARAM_DEFAULT;
        prm.in0_fn = IN_SEL_LO;
        prm.in1_fn = IN_SEL_HI;
        put_prm();
        for (int v = 0; v < 8; v++) begin
            settle(3'(v));
            chk_v("data_sel", {14'h0, v[1], v[0] | v[2]},
                  {14'h0, dsel});
        end
        $display("test run and select done");
        prm.in0_fn = IN_FORWARD;
        prm.in1_fn = IN_CLEAR;
        prm.in2_fn = IN_EXT_FAULT;
        put_prm();
        settle(3'h5);
        settle(3'h1);
        chk_v("ext_trip", 16'h0183,
              {7'h0, alarm, extf, y1, 4'h0, run});
        settle(3'h4);
        chk_v("alarm_held", 16'h0001, {15'h0, alarm});
        settle(3'h6);
        chk_v("alarm_clr", 16'h0001, {14'h0, alarm, y1});
        settle(3'h4);
        // any other protective trip latches until cleared
        fev = 1'b1;
        @(negedge clk);
        fev = 1'b0;
        @(negedge clk);
        chk_v("trip", 16'h0002, {14'h0, alarm, y1});
        settle(3'h6);
        chk_v("trip_clr", 16'h0001, {14'h0, alarm, y1});
        settle(3'h4);
        $display("test fault and clear done");
        prm.out0_fn = OUT_OVERLOAD;
        prm.ovl_delay = 10'h003;
        put_prm();
        region = 1'b1;
        wait_alarm(n);
        // three tenths, less up to one tick of prescaler phase
        chk_v("ovl_time", 16'h0001, {15'h0, n >= 22 && n <= 32});
        @(negedge clk);
        chk_v("ovl_flag", 16'h0000, {15'h0, y0});
        region = 1'b0;
        settle(3'h6);
        settle(3'h4);
        chk_v("ovl_idle", 16'h0001, {15'h0, y0});
        load = 8'd121;
        repeat (4) @(negedge clk);
        chk_v("warn_lvl", 16'h0000, {15'h0, y0});
        load = 8'd0;
        prm.ovl_delay = 10'h258;
        put_prm();
        severe = 1'b1;
        wait_alarm(n);
        chk_v("severe_time", 16'h0001, {15'h0, n >= 490 && n <= 510});
        severe = 1'b0;
        settle(3'h6);
        $display("test overload done");
        prm.out0_fn = OUT_MOVING;
        prm.out1_fn = OUT_REACHED;
        prm.speed_band = 9'h064;
        put_prm();
        cmd = 16'd1000;
        settle(3'h5);
        for (int i = 0; i < 6; i++) begin
            d = (i < 4) ? (i[0] ? 101 : 100) * (i[1] ? -1 : 1)
                : $urandom_range(0, 200) - 100;
            meas = 16'(1000 + d);
            repeat (4) @(negedge clk);
            chk_v("reached", {14'h0, 1'b1, d <= 100 && d >= -100},
                  {14'h0, y0, y1});
        end
        prm.out0_fn = OUT_CAUTION;
        prm.out1_fn = OUT_UNUSED;
        put_prm();
        warn = 1'b1;
        repeat (3) @(negedge clk);
        chk_v("caution", 16'h0002, {14'h0, y0, y1});
        warn = 1'b0;
        repeat (3) @(negedge clk);
        chk_v("caution_off", 16'h0000, {14'h0, y0, y1});
        prm.out0_fn = OUT_PULSE;
        put_prm();
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        n = 0;
        for (int c = 0; c < 20; c++) begin
            @(negedge clk);
            if (y0 === 1'b1) n++;
        end
        chk_v("pulse_len", 16'h0004, 16'(n));
        prm.hold_enable = 1'b1;
        prm.in1_fn = IN_HOLD_REL;
        put_prm();
        settle(3'h4);
        chk_v("hold", 16'h0001, {15'h0, hold});
        settle(3'h6);
        chk_v("hold_rel", 16'h0000, {15'h0, hold});
        $display("test outputs done");
        stop_test();
    end
endmodule : mdio_top_test
